// file: common/tcf_consts.vh
/*
  Constants for the capture/compare timer: APB register offsets, field
  positions inside the control registers, reset values and encodings.
  Assumes it is included by bare name from the design files.
*/
`ifndef TCF_CONSTS_VH
`define TCF_CONSTS_VH

// ==========================================================================
// Register byte offsets.
`define TCF_OFF_COUNT      12'h000
`define TCF_OFF_CCA        12'h004
`define TCF_OFF_CCB        12'h008
`define TCF_OFF_MODE       12'h00C
`define TCF_OFF_CAPCTL     12'h010
`define TCF_OFF_PRESC      12'h014
`define TCF_OFF_OUTCTL     12'h018
`define TCF_OFF_STATUS     12'h01C

// ==========================================================================
// Mode control register fields.
`define TCF_MODE_FIELD_HI  3
`define TCF_MODE_FIELD_LO  2
`define TCF_MODE_EDGE_TGL  1
`define TCF_MODE_OVF_BIT   0
`define TCF_MODE_STOP      2'h0
`define TCF_MODE_FREERUN   2'h1
`define TCF_MODE_EDGECLR   2'h2
`define TCF_MODE_MATCHCLR  2'h3

// ==========================================================================
// Capture control register fields.
`define TCF_CAP_A_IS_CAP   0
`define TCF_CAP_REVERSE    1
`define TCF_CAP_B_IS_CAP   2

// ==========================================================================
// Prescaler mode register fields.
`define TCF_PRE_ESB_HI     6
`define TCF_PRE_ESB_LO     5
`define TCF_PRE_ESA_HI     5
`define TCF_PRE_ESA_LO     4
`define TCF_PRE_ESB_SHIFT  5
`define TCF_PRE_ESA_SHIFT  4
`define TCF_PRE_DIV_HI     1
`define TCF_PRE_DIV_LO     0

// ==========================================================================
// Edge select encodings, shared by both trigger pins.
`define TCF_ES_FALL        2'h0
`define TCF_ES_RISE        2'h1
`define TCF_ES_NONE        2'h2
`define TCF_ES_BOTH        2'h3

// ==========================================================================
// Output control register fields.
`define TCF_OUT_ENABLE     0
`define TCF_OUT_INIT       2
`define TCF_OUT_MATCH_TGL  4

// ==========================================================================
// Reset values and count limits.
`define TCF_COUNT_MAX      16'hFFFF
`define TCF_COUNT_ZERO     16'h0000
`define TCF_RST_MODE       8'h00
`define TCF_RST_CAPCTL     8'h00
`define TCF_RST_PRESC      8'h00
`define TCF_RST_OUTCTL     8'h00

`endif

// file: design/tcf_edge_filter.v
/*
  Trigger pin noise filter and edge detector for one pin.
  Assumes the pin is synchronous to pclk and that sample_en pulses once per
  sampling clock period.
*/
`timescale 1ns/1ps

module tcf_edge_filter (
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  // Sampling.
  input  wire       sample_en,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  // Detected edges, one pclk wide.
  output reg        valid_edge,
  output reg        reverse_edge
);
`include "tcf_consts.vh"

  // ========================================================================
  // Sampling and filtering.
  reg        samp_reg;      // Previous raw sample.
  reg        level_reg;     // Accepted, filtered level.
  wire       rise;          // Filtered rising edge.
  wire       fall;          // Filtered falling edge.

  // The level changes only after two equal samples in a row, so a pulse
  // shorter than one sampling period never reaches the edge logic.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else if (clk_en && sample_en) begin
      samp_reg <= pin_in;
      if (samp_reg == pin_in)  // R21
        level_reg <= pin_in;
    end
  end

  assign rise = clk_en && sample_en && (samp_reg == pin_in) && pin_in && !level_reg;
  assign fall = clk_en && sample_en && (samp_reg == pin_in) && !pin_in && level_reg;

  // ========================================================================
  // Edge classification against the selected valid edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_edge   <= 1'b0;
      reverse_edge <= 1'b0;
    end else if (clk_en) begin
      case (edge_sel)
        `TCF_ES_FALL: begin
          valid_edge   <= fall;
          reverse_edge <= rise;
        end
        `TCF_ES_RISE: begin
          valid_edge   <= rise;
          reverse_edge <= fall;
        end
        `TCF_ES_BOTH: begin
          valid_edge   <= rise | fall;
          reverse_edge <= 1'b0;
        end
        default: begin
          valid_edge   <= 1'b0;
          reverse_edge <= 1'b0;
        end
      endcase
    end
  end

endmodule // tcf_edge_filter

// file: design/tcf_prescaler.v
/*
  Count clock and sampling clock enables.
  Assumes pclk is the peripheral clock; the enables are one pclk wide.
*/
`timescale 1ns/1ps

module tcf_prescaler #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  // Divider choice: 0 divides by 1, n by 2 to the power 2n.
  input  wire [1:0] div_sel,
  // Enables.
  output reg        count_tick,
  output reg        sample_tick
);

  // ========================================================================
  // Free divider; the count clock taps a bit chosen by div_sel.
  reg  [WIDTH-1:0] div_reg;   // Free running divider.
  wire [WIDTH-1:0] div_next;  // Divider plus one.
  reg              hit;       // Selected tap wraps this cycle.

  assign div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};

  // Pick the tap combinationally.
  always @* begin
    case (div_sel)
      2'h0:    hit = 1'b1;
      2'h1:    hit = (div_reg[1:0] == 2'h3);
      2'h2:    hit = (div_reg[3:0] == 4'hF);
      default: hit = (div_reg[5:0] == 6'h3F);
    endcase
  end

  // The sampling clock runs at full rate so filtering stays fine grained.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg     <= {WIDTH{1'b0}};
      count_tick  <= 1'b0;
      sample_tick <= 1'b0;
    end else if (clk_en) begin
      div_reg     <= div_next;
      count_tick  <= hit;
      sample_tick <= 1'b1;
    end
  end

endmodule // tcf_prescaler

// file: design/tcf_timer.v
/*
  Sixteen bit capture/compare timer with an APB register slave.
  Assumes trigger pins are synchronous to pclk and a single pclk domain.
*/
// What this block does
// R1: Edge-clear mode: pin A edge captures B, clears
// R2: Edge toggle bit inverts output on clear
// R3: Count equal A raises irq A, toggles
// R4: Compare matches never clear the counter
// R5: Count equal B raises irq B
// R6: Reverse phase captures A without irq A
// R7: Reverse phase: pin B edge irq only
// R8: Register A captures from pin A or B
// R9: Output unusable while pin B edges used; the enable is cut whenever register A captures pin B edges and their select is not none, even in stop mode
// R10: Register B captures only on pin A
// R11: Pin B edge select at bits 6:5
// R12: Both-edge pin A: capture, clear, toggle
// R13: Mode 01 counts up continuously
// R14: Wrap past FFFFH sets overflow flag
// R15: Software clears overflow flag itself
// R16: Free-run supports all register combinations
// R17: Match toggle on either register with irq
// R18: Counter read returns current count
// R19: Software reads captures after irq B
// R20: Mode 10 clears on pin A edge
// R21: Two equal samples accept an edge
// R22: Interrupts are single-cycle pulses
`timescale 1ns/1ps

module tcf_timer #(
  parameter PRE_WIDTH = 8
) (
  // Clock, reset and freeze.
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Trigger pins.
  input  wire        trigger_pin_a,
  input  wire        trigger_pin_b,
  // Timer output pin and its enable.
  output reg         timer_output_pin,
  output reg         timer_output_oe,
  // Interrupt pulses.
  output reg         match_irq_a,
  output reg         match_irq_b
);
`include "tcf_consts.vh"

  // ========================================================================
  // Registers.
  reg  [15:0] timer_count_reg;        // Counter.
  reg  [15:0] capture_compare_a_reg;  // Capture/compare A.
  reg  [15:0] capture_compare_b_reg;  // Capture/compare B.
  reg  [7:0]  mode_control_reg;       // Mode and edge toggle.
  reg  [7:0]  capture_control_reg;    // Capture configuration.
  reg  [7:0]  prescaler_mode_reg;     // Divider and edge selects.
  reg  [7:0]  output_control_reg;     // Output configuration.
  reg         overflow_flag_reg;      // Sticky overflow.
  reg         out_level_reg;          // Timer output level.

  // ========================================================================
  // Decoded controls.
  wire [1:0] mode_field;              // Operating mode.
  wire       edge_toggle_enable;      // Toggle on pin A clear.
  wire       a_is_capture;            // Register A captures.
  wire       b_is_capture;            // Register B captures.
  wire       reverse_phase_select;    // A captures on pin A reverse phase.
  wire [1:0] edge_sel_a;              // Pin A valid edge.
  wire [1:0] edge_sel_b;              // Pin B valid edge.
  wire       running;                 // Counter enabled.
  wire       count_tick;              // Count clock enable.
  wire       sample_tick;             // Sampling clock enable.
  wire       edge_a;                  // Pin A valid edge.
  wire       rev_a;                   // Pin A opposite edge.
  wire       edge_b;                  // Pin B valid edge.

  assign mode_field           = mode_control_reg[`TCF_MODE_FIELD_HI:`TCF_MODE_FIELD_LO];
  assign edge_toggle_enable   = mode_control_reg[`TCF_MODE_EDGE_TGL];
  assign a_is_capture         = capture_control_reg[`TCF_CAP_A_IS_CAP];
  assign reverse_phase_select = capture_control_reg[`TCF_CAP_REVERSE];
  assign b_is_capture         = capture_control_reg[`TCF_CAP_B_IS_CAP];
  assign edge_sel_a           = prescaler_mode_reg[`TCF_PRE_ESA_HI:`TCF_PRE_ESA_LO];
  assign edge_sel_b           = prescaler_mode_reg[`TCF_PRE_ESB_HI:`TCF_PRE_ESB_LO];  // R11
  assign running              = (mode_field != `TCF_MODE_STOP);

  // ========================================================================
  // Clock enables and edge detectors.
  tcf_prescaler #(
    .WIDTH       (PRE_WIDTH)
  ) u_pre (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .div_sel     (prescaler_mode_reg[`TCF_PRE_DIV_HI:`TCF_PRE_DIV_LO]),
    .count_tick  (count_tick),
    .sample_tick (sample_tick)
  );

  tcf_edge_filter u_edge_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .sample_en    (sample_tick),
    .pin_in       (trigger_pin_a),
    .edge_sel     (edge_sel_a),
    .valid_edge   (edge_a),
    .reverse_edge (rev_a)
  );

  tcf_edge_filter u_edge_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .sample_en    (sample_tick),
    .pin_in       (trigger_pin_b),
    .edge_sel     (edge_sel_b),
    .valid_edge   (edge_b),
    .reverse_edge ()
  );

  // ========================================================================
  // Events of this cycle.
  wire edge_clear;   // Pin A edge clears the counter.
  wire cap_a_pin_a;  // Register A captures on pin A reverse phase.
  wire cap_a_pin_b;  // Register A captures on pin B edge.
  wire cap_a;        // Register A capture strobe.
  wire cap_b;        // Register B capture strobe.
  wire cmp_a;        // Compare match on A.
  wire cmp_b;        // Compare match on B.
  wire irq_a_ev;     // Interrupt A cause.
  wire irq_b_ev;     // Interrupt B cause.
  wire match_tgl;    // Output toggle on compare match.
  wire pin_b_used;   // Pin B edges capture into register A.
  wire wrap;         // Counter wraps from all ones.
  wire toggle;       // Output toggles this cycle.

  assign edge_clear  = running && (mode_field == `TCF_MODE_EDGECLR) && edge_a;  // R20
  assign cap_a_pin_a = running && a_is_capture && reverse_phase_select && rev_a;  // R6
  assign cap_a_pin_b = running && a_is_capture && !reverse_phase_select && edge_b;  // R8
  assign cap_a       = cap_a_pin_a | cap_a_pin_b;
  assign cap_b       = running && b_is_capture && edge_a;  // R10
  // Compares are evaluated on count ticks only, so one pulse per count value.
  assign cmp_a       = running && count_tick && !a_is_capture
                       && (timer_count_reg == capture_compare_a_reg);  // R3
  assign cmp_b       = running && count_tick && !b_is_capture
                       && (timer_count_reg == capture_compare_b_reg);  // R5
  // Pin B edges still raise irq A in reverse phase, with no capture.
  assign irq_a_ev    = cmp_a | cap_a_pin_b
                       | (running && a_is_capture && reverse_phase_select && edge_b);  // R7
  assign irq_b_ev    = cmp_b | cap_b;  // R1
  assign match_tgl   = output_control_reg[`TCF_OUT_MATCH_TGL];
  assign pin_b_used  = a_is_capture && !reverse_phase_select && (edge_sel_b != `TCF_ES_NONE);
  assign toggle      = (match_tgl && (cmp_a | cmp_b))  // R17
                       | (edge_toggle_enable && edge_a && running
                          && (mode_field != `TCF_MODE_MATCHCLR));  // R2 R12
  assign wrap        = count_tick && (mode_field != `TCF_MODE_STOP)
                       && (timer_count_reg == `TCF_COUNT_MAX);

  // ========================================================================
  // Counter. A pin A clear wins over counting; matches never clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= `TCF_COUNT_ZERO;
    end else if (clk_en) begin
      if (!running) begin
        timer_count_reg <= `TCF_COUNT_ZERO;
      end else if (edge_clear) begin
        timer_count_reg <= `TCF_COUNT_ZERO;  // R1 R12
      end else if (count_tick) begin
        timer_count_reg <= timer_count_reg + 16'h0001;  // R13 R4 R14
      end
    end
  end

  // ========================================================================
  // Capture registers and software writes. Capture takes priority since
  // losing a measured edge is worse than losing a write in the same cycle.
  wire wr_en;  // APB write in access phase.
  assign wr_en = psel && penable && pwrite && clk_en;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_a_reg <= `TCF_COUNT_ZERO;
      capture_compare_b_reg <= `TCF_COUNT_ZERO;
      mode_control_reg      <= `TCF_RST_MODE;
      capture_control_reg   <= `TCF_RST_CAPCTL;
      prescaler_mode_reg    <= `TCF_RST_PRESC;
      output_control_reg    <= `TCF_RST_OUTCTL;
    end else if (clk_en) begin
      if (cap_a) begin
        capture_compare_a_reg <= timer_count_reg;  // R8 R16
      end else if (wr_en && paddr == `TCF_OFF_CCA) begin
        capture_compare_a_reg <= pwdata[15:0];
      end
      if (cap_b) begin
        capture_compare_b_reg <= timer_count_reg;  // R1 R10 R16
      end else if (wr_en && paddr == `TCF_OFF_CCB) begin
        capture_compare_b_reg <= pwdata[15:0];
      end
      if (wr_en && paddr == `TCF_OFF_MODE) begin
        mode_control_reg <= pwdata[7:0];
      end
      if (wr_en && paddr == `TCF_OFF_CAPCTL) begin
        capture_control_reg <= pwdata[7:0];
      end
      if (wr_en && paddr == `TCF_OFF_PRESC) begin
        prescaler_mode_reg <= pwdata[7:0];
      end
      if (wr_en && paddr == `TCF_OFF_OUTCTL) begin
        output_control_reg <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // Overflow flag. Set wins over a software clear in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (wrap) begin
        overflow_flag_reg <= 1'b1;  // R14
      end else if (wr_en && paddr == `TCF_OFF_STATUS && !pwdata[0]) begin
        overflow_flag_reg <= 1'b0;  // R15
      end
    end
  end

  // ========================================================================
  // Output level, pin and interrupts.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level_reg    <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_oe  <= 1'b0;
      match_irq_a      <= 1'b0;
      match_irq_b      <= 1'b0;
    end else if (clk_en) begin
      if (!output_control_reg[`TCF_OUT_ENABLE]) begin
        out_level_reg <= output_control_reg[`TCF_OUT_INIT];
      end else if (toggle) begin
        out_level_reg <= !out_level_reg;  // R3 R2
      end
      timer_output_pin <= out_level_reg;
      // The output cannot be shared with pin B edges capturing into register A.
      timer_output_oe  <= output_control_reg[`TCF_OUT_ENABLE] && !pin_b_used;  // R9
      match_irq_a      <= irq_a_ev;  // R22
      match_irq_b      <= irq_b_ev;  // R22
    end else begin
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
    end
  end

  // ========================================================================
  // APB slave: zero wait state, unmapped or misaligned reads return zero
  // with pslverr.
  reg [31:0] rd_mux;  // Read data selection.
  reg        rd_hit;  // Address is mapped.

  always @* begin
    rd_hit = 1'b1;
    case (paddr)
      `TCF_OFF_COUNT:  rd_mux = {16'h0000, timer_count_reg};  // R18
      `TCF_OFF_CCA:    rd_mux = {16'h0000, capture_compare_a_reg};
      `TCF_OFF_CCB:    rd_mux = {16'h0000, capture_compare_b_reg};
      `TCF_OFF_MODE:   rd_mux = {24'h000000, mode_control_reg};
      `TCF_OFF_CAPCTL: rd_mux = {24'h000000, capture_control_reg};
      `TCF_OFF_PRESC:  rd_mux = {24'h000000, prescaler_mode_reg};
      `TCF_OFF_OUTCTL: rd_mux = {24'h000000, output_control_reg};
      `TCF_OFF_STATUS: rd_mux = {31'h00000000, overflow_flag_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // pready is registered high for one cycle, the first access cycle after the setup phase is seen.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end


endmodule // tcf_timer

// file: test/tcf_timer_asserts.sv
/*
  Checker for tcf_timer: APB answer timing and interrupt pulse shape.
  Assumes it sees only the top module's ports; the bind sits at the foot.
*/
`timescale 1ns/1ps

module tcf_timer_asserts (
  // Clock, reset and freeze.
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  // APB handshake.
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupt pulses.
  input wire        match_irq_a,
  input wire        match_irq_b
);
  // ==========================================================
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Interrupts: one cycle per event, silent while frozen.
  property p_irq_a_one; match_irq_a |=> !match_irq_a; endproperty
  property p_irq_b_one; match_irq_b |=> !match_irq_b; endproperty
  property p_frozen; !clk_en |=> !(match_irq_a || match_irq_b); endproperty
  a_irq_a_one: assert property (p_irq_a_one) else $error("irq a wider than one cycle");
  a_irq_b_one: assert property (p_irq_b_one) else $error("irq b wider than one cycle");
  a_frozen: assert property (p_frozen) else $error("irq while frozen");

  // ==========================================================
  // APB: zero wait states, answer one cycle, data zero when idle.
  property p_answer; psel && !penable && clk_en |=> pready; endproperty
  property p_ready_acc; pready |-> psel && penable; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered next cycle");
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  a_err: assert property (p_err) else $error("error without ready or with data");
  a_idle: assert property (p_idle) else $error("read data not zero when idle");

  // Main scenarios reached.
  c_irq_a: cover property (match_irq_a);
  c_irq_b: cover property (match_irq_b);
  c_err: cover property (pslverr);
endmodule // tcf_timer_asserts

bind tcf_timer tcf_timer_asserts i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .prdata,
  .pready, .pslverr, .match_irq_a, .match_irq_b);

// file: test/tcf_pin_model.sv
/*
  Model of the pins around the timer: drives both trigger pins and
  resolves the output pin. Assumes one pclk and levels held per call.
*/
`timescale 1ns/1ps

module tcf_pin_model (
  // Clock.
  input  wire  pclk,
  // Trigger levels seen by the timer.
  output logic trigger_pin_a,
  output logic trigger_pin_b,
  // Output pin; pulled up when not driven.
  input  wire  timer_output_pin,
  input  wire  timer_output_oe,
  output wire  out_level
);
  // ==========================================================
  // Pins rest low until a scenario moves them.
  initial begin
    trigger_pin_a = 1'b0;
    trigger_pin_b = 1'b0;
  end

  // Move one pin after an edge, then hold it; long holds let the filter accept.
  task automatic drive(input bit sel_b, input logic lvl, input int hold);
    @(posedge pclk);
    if (sel_b) trigger_pin_b <= lvl;
    else trigger_pin_a <= lvl;
    repeat (hold) @(posedge pclk);
  endtask

  // A released pin floats to the pull-up level, not its last value.
  assign out_level = timer_output_oe ? timer_output_pin : 1'b1;
endmodule // tcf_pin_model

// file: test/tcf_timer_bench.sv
/*
  Self-checking bench for tcf_timer through APB and the pin model.
  Assumes divider 1, so the count moves every pclk.
*/
`timescale 1ns/1ps
`include "tcf_consts.vh"
`define CHK(nm,e,g) begin n_checks++; if ((g)!==(e)) begin mismatches++; $display("Error %s exp %h got %h",nm,e,g); end end

module tcf_timer_bench;
  // ==========================================================
  // Design ports.
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, q, q0, q1;
  wire  [31:0] prdata;
  wire         pready, pslverr, trigger_pin_a, trigger_pin_b;
  wire         timer_output_pin, timer_output_oe, match_irq_a, match_irq_b, out_level;
  // Event tallies, base marks and verdict counters.
  int          na, nb, tg, a0, b0, t0, cyc, mismatches, n_checks;
  logic        last_out, err;

  tcf_timer i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trigger_pin_a, .trigger_pin_b, .timer_output_pin, .timer_output_oe,
    .match_irq_a, .match_irq_b);
  tcf_pin_model i_pins (.pclk, .trigger_pin_a, .trigger_pin_b, .timer_output_pin,
    .timer_output_oe, .out_level);

  // 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Tally interrupts and output toggles; a hang ends the run.
  always @(posedge pclk) begin
    last_out <= timer_output_pin;
    if (match_irq_a === 1'b1) na <= na + 1;
    if (match_irq_b === 1'b1) nb <= nb + 1;
    if (presetn && timer_output_pin !== last_out) tg <= tg + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // An idle cycle keeps two transfers from driving one signal twice.
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, q);
  endtask
  // Mark tallies, then compare growth; a negative toggle figure skips the toggle tally.
  task automatic mark;
    a0 = na;
    b0 = nb;
    t0 = tg;
  endtask
  task automatic ev(input int ea, input int eb, input int et);
    `CHK("irq a count", ea, na - a0)
    `CHK("irq b count", eb, nb - b0)
    if (et >= 0) `CHK("toggles", et, tg - t0)
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {na, nb, tg, cyc, mismatches, n_checks, last_out} = '0;
    clk_en = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped place, read-only count.
    for (int i = 0; i < 8; i++) begin
      if (i == 1 || i == 2) continue;
      rd(12'(i * 4));
      `CHK("reset value", 32'h0, q)
    end
    rd(12'h020);
    `CHK("unmapped err", 1'b1, err)
    wr(`TCF_OFF_COUNT, 32'h0000_1234);
    rd(`TCF_OFF_COUNT);
    `CHK("count ro", 32'h0, q)
    // Free run, both compare.
    wr(`TCF_OFF_CCA, 32'h0000_0010);
    wr(`TCF_OFF_CCB, 32'h0000_0020);
    rd(`TCF_OFF_CCB);
    `CHK("ccb rw", 32'h0000_0020, q)
    wr(`TCF_OFF_OUTCTL, 32'h0000_0013);
    mark();
    wr(`TCF_OFF_MODE, 32'h0000_0004);
    rd(`TCF_OFF_COUNT);
    q0 = q;
    rd(`TCF_OFF_COUNT);
    `CHK("count step", 32'h3, q - q0)
    repeat (60) @(posedge pclk);
    ev(1, 1, 2);
    rd(`TCF_OFF_COUNT);
    `CHK("not cleared", 1'b1, q > 32'h30)
    // Freeze for 20 cycles between two reads.
    rd(`TCF_OFF_COUNT);
    q0 = q;
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    rd(`TCF_OFF_COUNT);
    `CHK("frozen count", 32'h3, q - q0)
    // Overflow sets and stays until software clears it.
    repeat (65536) @(posedge pclk);
    rd(`TCF_OFF_STATUS);
    `CHK("overflow", 32'h1, q)
    rd(`TCF_OFF_STATUS);
    `CHK("overflow held", 32'h1, q)
    wr(`TCF_OFF_STATUS, 32'h0);
    rd(`TCF_OFF_STATUS);
    `CHK("overflow clr", 32'h0, q)
    // Pin A clear mode, both capture, both edges on pin A.
    wr(`TCF_OFF_PRESC, 32'h0000_0030);
    wr(`TCF_OFF_CAPCTL, 32'h0000_0005);
    wr(`TCF_OFF_MODE, 32'h0000_000A);
    for (int i = 1; i >= 0; i--) begin
      mark();
      rd(`TCF_OFF_COUNT);
      q0 = q;
      i_pins.drive(0, i[0], 8);
      ev(0, 1, 1);
      rd(`TCF_OFF_CCB);
      `CHK("ccb capture", 1'b1, q - q0 < 32'd20)
      rd(`TCF_OFF_COUNT);
      `CHK("cleared", 1'b1, q < 32'h10)
    end
    `CHK("oe pin b used", 1'b0, timer_output_oe)
    // Pin B rise, then a fall under both-edge select, into register A.
    mark();
    rd(`TCF_OFF_COUNT);
    q0 = q;
    i_pins.drive(1, 1'b1, 8);
    ev(1, 0, -1);
    rd(`TCF_OFF_CCA);
    `CHK("cca capture", 1'b1, q - q0 < 32'd20)
    wr(`TCF_OFF_PRESC, 32'h0000_0070);
    i_pins.drive(1, 1'b0, 8);
    ev(2, 0, -1);
    wr(`TCF_OFF_PRESC, 32'h0000_0050);
    repeat (2) @(posedge pclk);
    `CHK("oe free", 1'b1, timer_output_oe)
    `CHK("pin level", timer_output_pin, out_level)
    // Pulse width: reverse phase into A, fall into B.
    wr(`TCF_OFF_PRESC, 32'h0000_0000);
    wr(`TCF_OFF_CAPCTL, 32'h0000_0007);
    i_pins.drive(1, 1'b1, 4);
    mark();
    i_pins.drive(0, 1'b1, 50);
    i_pins.drive(0, 1'b0, 8);
    ev(0, 1, -1);
    rd(`TCF_OFF_CCA);
    q1 = q;
    rd(`TCF_OFF_CCB);
    `CHK("high width", 32'd51, q - q1)
    mark();
    i_pins.drive(1, 1'b0, 8);
    ev(1, 0, -1);
    rd(`TCF_OFF_CCA);
    `CHK("no capture", q1, q)
    i_pins.drive(0, 1'b1, 0);
    i_pins.drive(0, 1'b0, 8);
    rd(`TCF_OFF_CCA);
    `CHK("glitch", q1, q)
    wrap_up();
  end
endmodule // tcf_timer_bench
